/* gpm_defines.vh */
`ifndef GPM_DEFINES_VH
`define GPM_DEFINES_VH
// register byte offsets
`define GPM_CTRL 12'h000
`define GPM_MODE 12'h004
`define GPM_RATED 12'h008
`define GPM_SC_CFG 12'h00c
`define GPM_OS_CFG 12'h010
`define GPM_STOP_CFG 12'h014
`define GPM_CRANK_CFG 12'h018
`define GPM_BRK_CFG 12'h01c
`define GPM_FUEL_CONTACT_CFG 12'h020
`define GPM_FUEL_MIN_CFG 12'h024
`define GPM_FUEL_LOW_CFG 12'h028
`define GPM_MEAS_I 12'h02c
`define GPM_MEAS_SPEED 12'h030
`define GPM_STATUS 12'h034
`define GPM_CLEAR 12'h038
// operating modes
`define GPM_MODE_MAN 2'd0
`define GPM_MODE_AUTO 2'd1
`define GPM_MODE_TEST 2'd2
`define GPM_MODE_REMOTE 2'd3
// rated speeds in rpm
`define GPM_RPM_50HZ 16'd1500
`define GPM_RPM_60HZ 16'd1800
// tick period 1 ms at 100 MHz
`define GPM_TICK_NS 32'd1000000
`define GPM_CLK_NS 32'd10
`define GPM_TICK_CYCLES (`GPM_TICK_NS / `GPM_CLK_NS)
// consecutive breaker open attempts in auto
`define GPM_BRK_ATTEMPTS 2'd3
// status bits
`define GPM_ST_SC 0
`define GPM_ST_OS_SPD 1
`define GPM_ST_OS_FRQ 2
`define GPM_ST_NOSTOP 3
`define GPM_ST_CRANK 4
`define GPM_ST_MBNO 5
`define GPM_ST_GBNO 6
`define GPM_ST_FMIN 7
`define GPM_ST_FLOW 8
`define GPM_NEV 9
`endif

/* gpm_tick.v */
`default_nettype none
module gpm_tick #(
  parameter CYCLES = 100000
) (
  input wire clk_i,
  input wire rst_i,
  output reg tick_o
);
  reg [31:0] cnt;
  // periodic one-cycle tick for all delay timers
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else if (cnt == CYCLES - 1) begin
      cnt <= 32'h0000_0000;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 32'h0000_0001;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* gpm_persist.v */
`default_nettype none
module gpm_persist #(
  parameter W = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire tick_i,
  input wire cond_i,
  input wire [W-1:0] delay_i,
  output reg hit_o
);
  reg [W-1:0] cnt;
  // counts ticks while the condition holds; zero delay disables
  always @(posedge clk_i) begin
    if (rst_i || !cond_i || delay_i == {W{1'b0}}) begin
      cnt <= {W{1'b0}};
      hit_o <= 1'b0;
    end else if (tick_i && cnt != delay_i) begin
      cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
      hit_o <= (cnt + {{(W-1){1'b0}}, 1'b1}) == delay_i;
    end
  end
endmodule
`default_nettype wire

/* gpm_monitor.v */
`default_nettype none
`include "gpm_defines.vh"
// Behaviour
// - short circuit: any phase over threshold
// - threshold is percent of rated current
// - short circuit ignores inverse-time curve
// - short circuit class block or deactivation only
// - speed overspeed armed fuel on, in tolerance
// - speed over percent of rated rpm
// - frequency overspeed with fuel, outside start/stop
// - engine not stopped within stop time
// - not-stopped alarm rises despite other events
// - over-crank after configured failed attempts
// - mains breaker closed while commanded open
// - auto mode needs three failed open attempts
// - mains breaker class deactivation or warning
// - genset breaker closed while commanded open
// - genset breaker class block or warning
// - minimum fuel contact persists for delay
// - low fuel contact persists for delay
// - analogue level at/below minimum threshold
// - analogue level at/below low threshold
module gpm_monitor #(
  parameter TICK_CYCLES = `GPM_TICK_CYCLES
) (
  input wire clk_i,
  input wire rst_i,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [15:0] phase_current_a_i,
  input wire [15:0] phase_current_b_i,
  input wire [15:0] phase_current_c_i,
  input wire [15:0] engine_speed_i,
  input wire [15:0] gen_freq_i,
  input wire [7:0] fuel_level_i,
  input wire fuel_cmd_i,
  input wire start_stop_phase_i,
  input wire speed_in_tol_i,
  input wire stop_cmd_i,
  input wire engine_stopped_i,
  input wire start_attempt_i,
  input wire engine_running_i,
  input wire mains_breaker_open_cmd_i,
  input wire mains_breaker_closed_i,
  input wire genset_breaker_open_cmd_i,
  input wire genset_breaker_closed_i,
  input wire minimum_fuel_contact_i,
  input wire low_fuel_contact_i,
  output reg [8:0] events_o,
  output reg sc_deactivation_o,
  output reg mains_breaker_deactivation_o,
  output reg genset_breaker_block_o
);
  // software registers
  reg [31:0] ctrl;
  reg [1:0] mode;
  reg [15:0] rated_current;
  reg [31:0] sc_cfg;
  reg [31:0] os_cfg;
  // overspeed delay kept in its own register field
  reg [15:0] os_dly;
  reg [15:0] stop_delay;
  reg [3:0] crank_limit;
  reg [15:0] brk_delay;
  reg [31:0] fuel_contact_cfg;
  reg [31:0] fuel_min_cfg;
  reg [31:0] fuel_low_cfg;
  reg [8:0] status;
  reg [3:0] crank_fails;
  reg [1:0] mb_tries;
  reg [1:0] gb_tries;
  reg stop_armed;
  reg started_here;
  reg attempt_pending;
  reg mb_prev;
  reg gb_prev;
  wire tick;
  wire [8:0] hit;
  wire [8:0] raw;
  wire wr;
  wire [31:0] rated_rpm;
  wire [31:0] sc_lim;
  wire [31:0] spd_lim;
  wire [15:0] frq_lim;
  wire auto_any;
  wire prot_en;
  wire mb_cond;
  wire gb_cond;
  wire mb_fire;
  wire gb_fire;
  wire [15:0] stop_cnt_delay;

  // percent of a base value, rounded down
  function [31:0] pct;
    input [15:0] base;
    input [15:0] p;
    begin
      pct = ({16'h0000, base} * {16'h0000, p}) / 32'd100;
    end
  endfunction

  // one common tick drives all timers
  gpm_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  assign wr = psel && penable && pwrite;
  assign auto_any = mode != `GPM_MODE_MAN;
  // fuel on and outside start/stop phases
  assign prot_en = fuel_cmd_i && !start_stop_phase_i;
  assign sc_lim = pct(rated_current, sc_cfg[15:0]);
  assign rated_rpm = ctrl[1] ? {16'h0000, `GPM_RPM_60HZ} :
    {16'h0000, `GPM_RPM_50HZ};
  assign spd_lim = pct(rated_rpm[15:0], os_cfg[15:0]);
  assign frq_lim = os_cfg[31:16];
  assign mb_cond = ctrl[2] && mains_breaker_open_cmd_i &&
    mains_breaker_closed_i;
  assign gb_cond = ctrl[3] && genset_breaker_open_cmd_i &&
    genset_breaker_closed_i;
  assign stop_cnt_delay = stop_armed ? stop_delay : 16'h0000;

  // raw conditions as plain level terms; the crank bit is tied low
  assign raw[`GPM_ST_SC] = prot_en && (
    {16'h0000, phase_current_a_i} > sc_lim ||
    {16'h0000, phase_current_b_i} > sc_lim ||
    {16'h0000, phase_current_c_i} > sc_lim);
  assign raw[`GPM_ST_OS_SPD] = prot_en && speed_in_tol_i &&
    {16'h0000, engine_speed_i} > spd_lim;
  assign raw[`GPM_ST_OS_FRQ] = prot_en && gen_freq_i > frq_lim;
  assign raw[`GPM_ST_NOSTOP] = stop_armed && !engine_stopped_i;
  assign raw[`GPM_ST_CRANK] = 1'b0;
  assign raw[`GPM_ST_MBNO] = mb_cond;
  assign raw[`GPM_ST_GBNO] = gb_cond;
  assign raw[`GPM_ST_FMIN] = (ctrl[4] && minimum_fuel_contact_i) ||
    (ctrl[5] && fuel_level_i <= fuel_min_cfg[7:0]);
  assign raw[`GPM_ST_FLOW] = (ctrl[4] && low_fuel_contact_i) ||
    (ctrl[5] && fuel_level_i <= fuel_low_cfg[7:0]);

  // persistence timers, one per timed protection
  genvar g;
  generate
    for (g = 0; g < `GPM_NEV; g = g + 1) begin : g_pers
      wire [15:0] dly;
      if (g == `GPM_ST_SC) begin : g_d
        assign dly = sc_cfg[31:16];
      end else if (g == `GPM_ST_OS_SPD || g == `GPM_ST_OS_FRQ) begin : g_d
        assign dly = os_dly;
      end else if (g == `GPM_ST_NOSTOP) begin : g_d
        assign dly = stop_cnt_delay;
      end else if (g == `GPM_ST_CRANK) begin : g_d
        assign dly = 16'h0000;
      end else if (g == `GPM_ST_MBNO || g == `GPM_ST_GBNO) begin : g_d
        assign dly = brk_delay;
      end else if (g == `GPM_ST_FMIN) begin : g_d
        assign dly = ctrl[5] ? fuel_min_cfg[31:16] :
          fuel_contact_cfg[15:0];
      end else begin : g_d
        assign dly = ctrl[5] ? fuel_low_cfg[31:16] :
          fuel_contact_cfg[31:16];
      end
      gpm_persist #(.W(16)) u_p (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .cond_i(raw[g]),
        .delay_i(dly),
        .hit_o(hit[g])
      );
    end
  endgenerate

  // auto mode counts three failed open attempts first
  assign mb_fire = hit[`GPM_ST_MBNO] && !mb_prev &&
    (!auto_any || mb_tries == `GPM_BRK_ATTEMPTS - 2'd1);
  assign gb_fire = hit[`GPM_ST_GBNO] && !gb_prev &&
    (mode != `GPM_MODE_AUTO || gb_tries == `GPM_BRK_ATTEMPTS - 2'd1);

  // apb writes, sticky events, set wins over clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= 32'h0000_0000;
      mode <= `GPM_MODE_MAN;
      rated_current <= 16'h0000;
      sc_cfg <= 32'h0000_0000;
      os_cfg <= 32'h0000_0000;
      os_dly <= 16'h0000;
      stop_delay <= 16'h0000;
      crank_limit <= 4'h0;
      brk_delay <= 16'h0000;
      fuel_contact_cfg <= 32'h0000_0000;
      fuel_min_cfg <= 32'h0000_0000;
      fuel_low_cfg <= 32'h0000_0000;
      status <= 9'h000;
      crank_fails <= 4'h0;
      mb_tries <= 2'd0;
      gb_tries <= 2'd0;
      stop_armed <= 1'b0;
      started_here <= 1'b0;
      attempt_pending <= 1'b0;
      mb_prev <= 1'b0;
      gb_prev <= 1'b0;
    end else begin
      if (wr) begin
        case (paddr)
          `GPM_CTRL: ctrl <= pwdata;
          `GPM_MODE: mode <= pwdata[1:0];
          `GPM_RATED: rated_current <= pwdata[15:0];
          `GPM_SC_CFG: sc_cfg <= pwdata;
          `GPM_OS_CFG: os_dly <= pwdata[15:0];
          `GPM_STOP_CFG: stop_delay <= pwdata[15:0];
          `GPM_CRANK_CFG: crank_limit <= pwdata[3:0];
          `GPM_BRK_CFG: brk_delay <= pwdata[15:0];
          `GPM_FUEL_CONTACT_CFG: fuel_contact_cfg <= pwdata;
          `GPM_FUEL_MIN_CFG: fuel_min_cfg <= pwdata;
          `GPM_FUEL_LOW_CFG: fuel_low_cfg <= pwdata;
          `GPM_MEAS_I: os_cfg <= pwdata;
          default: ;
        endcase
      end
      mb_prev <= hit[`GPM_ST_MBNO];
      gb_prev <= hit[`GPM_ST_GBNO];
      // count failed open attempts; cleared once the breaker opens
      if (!ctrl[2] || !mains_breaker_closed_i)
        mb_tries <= 2'd0;
      else if (hit[`GPM_ST_MBNO] && !mb_prev && !mb_fire)
        mb_tries <= mb_tries + 2'd1;
      if (!ctrl[3] || !genset_breaker_closed_i)
        gb_tries <= 2'd0;
      else if (hit[`GPM_ST_GBNO] && !gb_prev && !gb_fire)
        gb_tries <= gb_tries + 2'd1;
      // stop supervision for an engine started here
      if (fuel_cmd_i)
        started_here <= 1'b1;
      if (stop_cmd_i && started_here && auto_any)
        stop_armed <= 1'b1;
      else if (engine_stopped_i) begin
        stop_armed <= 1'b0;
        started_here <= 1'b0;
      end
      // crank attempts in automatic modes
      if (!auto_any || engine_running_i) begin
        crank_fails <= 4'h0;
        attempt_pending <= 1'b0;
      end else if (start_attempt_i) begin
        attempt_pending <= 1'b1;
      end else if (attempt_pending && !start_attempt_i) begin
        attempt_pending <= 1'b0;
        crank_fails <= crank_fails + 4'h1;
      end
      // clear then set, so a fresh event survives its clear
      status <= (status & ~((wr && paddr == `GPM_CLEAR) ?
        pwdata[8:0] : 9'h000)) |
        {hit[8:7], gb_fire, mb_fire,
         (crank_limit != 4'h0 && crank_fails >= crank_limit),
         hit[3:0]};
    end
  end

  // apb slave: zero wait, unmapped reads zero with error
  always @(posedge clk_i) begin
    if (rst_i) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          `GPM_CTRL: prdata <= ctrl;
          `GPM_MODE: prdata <= {30'h0, mode};
          `GPM_RATED: prdata <= {16'h0000, rated_current};
          `GPM_SC_CFG: prdata <= sc_cfg;
          `GPM_OS_CFG: prdata <= {16'h0000, os_dly};
          `GPM_STOP_CFG: prdata <= {16'h0000, stop_delay};
          `GPM_CRANK_CFG: prdata <= {28'h0, crank_limit};
          `GPM_BRK_CFG: prdata <= {16'h0000, brk_delay};
          `GPM_FUEL_CONTACT_CFG: prdata <= fuel_contact_cfg;
          `GPM_FUEL_MIN_CFG: prdata <= fuel_min_cfg;
          `GPM_FUEL_LOW_CFG: prdata <= fuel_low_cfg;
          `GPM_MEAS_I: prdata <= os_cfg;
          `GPM_MEAS_SPEED: prdata <= {rated_rpm[15:0], engine_speed_i};
          `GPM_STATUS: prdata <= {23'h0, status};
          `GPM_CLEAR: prdata <= 32'h0000_0000;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // outputs and event classes
  always @(posedge clk_i) begin
    if (rst_i) begin
      events_o <= 9'h000;
      sc_deactivation_o <= 1'b0;
      mains_breaker_deactivation_o <= 1'b0;
      genset_breaker_block_o <= 1'b0;
    end else begin
      events_o <= status;
      sc_deactivation_o <= ctrl[0];
      mains_breaker_deactivation_o <= auto_any && ctrl[6];
      genset_breaker_block_o <= mode == `GPM_MODE_AUTO &&
        engine_running_i && ctrl[7];
    end
  end
endmodule
`default_nettype wire

/* gpm_monitor_props.sv */
`default_nettype none
module gpm_monitor_props #(
  parameter TICK_CYCLES = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] phase_current_a_i,
  input wire logic [15:0] phase_current_b_i,
  input wire logic [15:0] phase_current_c_i,
  input wire logic fuel_cmd_i,
  input wire logic start_stop_phase_i,
  input wire logic speed_in_tol_i,
  input wire logic engine_stopped_i,
  input wire logic engine_running_i,
  input wire logic mains_breaker_open_cmd_i,
  input wire logic mains_breaker_closed_i,
  input wire logic genset_breaker_open_cmd_i,
  input wire logic genset_breaker_closed_i,
  input wire logic [8:0] events_o,
  input wire logic genset_breaker_block_o
);
  logic [5:0] cause;
  logic [3:0] age [6];
  int cnt;
  // conditions that may lead to each watched event
  assign cause = {genset_breaker_open_cmd_i & genset_breaker_closed_i,
    mains_breaker_open_cmd_i & mains_breaker_closed_i, ~engine_stopped_i,
    fuel_cmd_i & ~start_stop_phase_i,
    fuel_cmd_i & speed_in_tol_i & ~start_stop_phase_i,
    |{phase_current_a_i, phase_current_b_i, phase_current_c_i}};
  // cycles since each cause was last seen, saturating
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < 6; k++) begin
      if (rst_i) age[k] <= 4'hf;
      else if (cause[k]) age[k] <= 4'h0;
      else if (age[k] != 4'hf) age[k] <= age[k] + 4'h1;
    end
  end
  // cycles since reset, so no event can beat the first tick
  always_ff @(posedge clk_i) begin
    if (rst_i) cnt <= 0;
    else if (cnt < TICK_CYCLES) cnt <= cnt + 1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_sc_cause: assert property ($rose(events_o[0]) |-> age[0] < 4'h8)
    else $error("short circuit without current");
  a_spd_armed: assert property ($rose(events_o[1]) |-> age[1] < 4'h8)
    else $error("speed overspeed while not armed");
  a_frq_armed: assert property ($rose(events_o[2]) |-> age[2] < 4'h8)
    else $error("frequency overspeed while not armed");
  a_nostop_cause: assert property ($rose(events_o[3]) |-> age[3] < 4'h8)
    else $error("not stopped alarm on a stopped engine");
  a_mains_cause: assert property ($rose(events_o[5]) |-> age[4] < 4'h8)
    else $error("mains breaker event without cause");
  a_genset_cause: assert property ($rose(events_o[6]) |-> age[5] < 4'h8)
    else $error("genset breaker event without cause");
  a_block_run: assert property (genset_breaker_block_o |->
    engine_running_i || $past(engine_running_i) || $past(engine_running_i, 2))
    else $error("genset block class without running engine");
  a_tick_first: assert property ($rose(|events_o) |-> cnt >= TICK_CYCLES)
    else $error("event before the first tick");
endmodule
bind gpm_monitor gpm_monitor_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (.*);
`default_nettype wire

/* gpm_fuel_model.sv */
`default_nettype none
module gpm_fuel_model (
  input wire logic clk_i,
  input wire logic min_req_i,
  input wire logic low_req_i,
  input wire logic [7:0] level_req_i,
  output logic minimum_fuel_contact_o,
  output logic low_fuel_contact_o,
  output logic [7:0] fuel_level_o
);
  // float contacts and level sensor start open and full
  initial begin
    minimum_fuel_contact_o = 1'b0;
    low_fuel_contact_o = 1'b0;
    fuel_level_o = 8'h64;
  end
  // sensors settle one cycle after the requested tank state
  always @(posedge clk_i) begin
    minimum_fuel_contact_o <= min_req_i;
    low_fuel_contact_o <= low_req_i;
    fuel_level_o <= level_req_i;
  end
endmodule
`default_nettype wire

/* tb_top.sv */
`default_nettype none
`include "gpm_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r = 0, s = 0;
  logic pready, pslverr, running = 0, min_req = 0, low_req = 0;
  logic mfc, lfc, scd, mbd, gbb, fuel_on = 0;
  logic [7:0] level_req = 8'h64, lvl;
  logic [8:0] ev;
  logic [33:0] notes [$];
  int mismatches = 0, cmp_count = 0, md;
  gpm_monitor #(.TICK_CYCLES(10)) i_gpm_monitor (.clk_i(clk_i),
    .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phase_current_a_i(r[15:0]),
    .phase_current_b_i(r[31:16]), .phase_current_c_i(s[15:0]),
    .engine_speed_i(s[31:16]), .gen_freq_i(r[23:8]), .fuel_level_i(lvl),
    .fuel_cmd_i(s[0] | fuel_on), .start_stop_phase_i(s[1] & !fuel_on),
    .speed_in_tol_i(s[2]),
    .stop_cmd_i(s[3]), .engine_stopped_i(s[4]), .start_attempt_i(1'b0),
    .engine_running_i(running), .mains_breaker_open_cmd_i(s[5]),
    .mains_breaker_closed_i(s[6]), .genset_breaker_open_cmd_i(s[7]),
    .genset_breaker_closed_i(s[8]), .minimum_fuel_contact_i(mfc),
    .low_fuel_contact_i(lfc), .events_o(ev), .sc_deactivation_o(scd),
    .mains_breaker_deactivation_o(mbd), .genset_breaker_block_o(gbb));
  gpm_fuel_model i_gpm_fuel_model (.clk_i(clk_i), .min_req_i(min_req),
    .low_req_i(low_req), .level_req_i(level_req),
    .minimum_fuel_contact_o(mfc), .low_fuel_contact_o(lfc),
    .fuel_level_o(lvl));
  // clock and random engine activity
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    r <= $urandom;
    s <= $urandom;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic e = 0);
    int n;
    n = 0;
    @(posedge clk_i);
    notes.push_back({w, e, d});
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1;
    @(posedge clk_i);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20) mismatches++;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic hold(int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // completed transfers are compared against the oldest note
  always @(posedge clk_i) begin
    if (psel && penable && pready === 1'b1) begin
      logic [33:0] t;
      t = notes.pop_front();
      chk("pslverr", {31'h0, t[32]}, {31'h0, pslverr});
      if (!t[33]) chk("prdata", t[31:0], prdata);
    end
  end
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
  initial begin
    void'($urandom(69655));
    hold(8);
    rst_i <= 0;
    apb(0, `GPM_STATUS, 0);
    apb(0, 12'h03c, 0, 1);
    apb(1, `GPM_CTRL, 32'h0000_00d1);
    apb(0, `GPM_CTRL, 32'h0000_00d1);
    hold(2);
    chk("sc_class", 1, {31'h0, scd});
    for (int m = 0; m < 5; m++) begin
      md = (m == 4) ? 1 : m;
      running <= (m != 4);
      apb(1, `GPM_MODE, md);
      hold(3);
      chk("mains_class", md != 0, {31'h0, mbd});
      chk("genset_class", md == 1 && m != 4, {31'h0, gbb});
    end
    apb(1, `GPM_FUEL_CONTACT_CFG, 32'h0000_0003);
    low_req <= 1;
    repeat (3) begin
      min_req <= 1;
      hold(19);
      min_req <= 0;
      hold(5);
    end
    apb(0, `GPM_STATUS, 0);
    min_req <= 1;
    hold(60);
    apb(0, `GPM_STATUS, 32'h0000_0080);
    chk("events", 32'h0000_0080, {23'h0, ev});
    apb(1, `GPM_FUEL_CONTACT_CFG, 32'h0002_0003);
    hold(60);
    apb(0, `GPM_STATUS, 32'h0000_0180);
    min_req <= 0;
    low_req <= 0;
    hold(5);
    apb(1, `GPM_CLEAR, 32'h0000_01ff);
    apb(0, `GPM_STATUS, 0);
    apb(1, `GPM_CTRL, 32'h0000_00e1);
    apb(1, `GPM_FUEL_MIN_CFG, 32'h0002_0014);
    apb(1, `GPM_FUEL_LOW_CFG, 32'h0002_001e);
    repeat (12) begin
      level_req <= 8'($urandom_range(100, 31));
      hold(5);
    end
    apb(0, `GPM_STATUS, 0);
    level_req <= 8'h1e;
    hold(40);
    apb(0, `GPM_STATUS, 32'h0000_0100);
    level_req <= 8'h14;
    hold(40);
    apb(0, `GPM_STATUS, 32'h0000_0180);
    // fuel held on, random phase currents far above a 100 limit
    fuel_on <= 1;
    apb(1, `GPM_RATED, 32'h0000_0064);
    apb(1, `GPM_SC_CFG, 32'h0002_0064);
    hold(40);
    apb(0, `GPM_STATUS, 32'h0000_0181);
    chk("events", 32'h0000_0181, {23'h0, ev});
    hold(2);
    give_verdict();
  end
endmodule
`default_nettype wire
